//--- hdl/aux_ctrl.sv
`timescale 1ns/1ns
// device end: aux register, dual pointers, info space, programming slave
module aux_ctrl (
  input  wire logic                CLK_I,       // core clock
  input  wire logic                SYS_RST_I,   // chip reset, sync high
  input  wire logic                CE_I,        // clock enable
  input  wire logic                PROG_MODE_I, // programming mode entered
  input  wire aux_pkg::core_op_t   OP_I,        // core pointer/aux operation
  input  wire logic [15:0]         OP_DATA_I,   // operand for op
  input  wire logic                JMP_I,       // indirect jump request
  input  wire logic                CODE_RD_I,   // code read request
  input  wire logic                XDATA_RD_I,  // external data read request
  input  wire logic [7:0]          ACC_I,       // accumulator
  input  wire logic [7:0]          CODE_DATA_I, // main code memory byte
  output logic [15:0]              CODE_ADDR_O, // code address for read
  output logic [15:0]              JMP_TGT_O,   // jump target
  output logic                     JMP_VLD_O,   // jump target valid pulse
  output logic [7:0]               RD_DATA_O,   // read result to accumulator
  output logic                     RD_VLD_O,    // read result valid pulse
  output logic [7:0]               AUX_O,       // aux register readback
  output logic [7:0]               DPL_O,       // selected pointer low byte
  output logic [7:0]               DPH_O,       // selected pointer high byte
  output logic                     SOFT_RST_O,  // core reset pulse
  output logic                     WDT_RST_EN_O, // watchdog may reset
  output logic                     RST_PIN_EN_O, // reset pin active
  output logic                     PORT_RST_HI_O, // port reset level
  output aux_pkg::osc_t            OSC_SEL_O,   // decoded clock source
  prog_link_if.device              link         // serial programming pins
);
  typedef struct packed {
    logic [7:0]       aux;        // aux control register
    logic [1:0][15:0] data_pointer;       // two data pointers
    logic [31:0][7:0] cust;       // customer area
    logic [7:0]       cfg;        // config storage
    logic [7:0]       cfg_lat;    // latched config
    logic [15:0]      sh;         // serial shift
    logic [4:0]       cnt;        // bit count
    logic             pclk_d;     // strobe edge history
    logic             rd_pend;    // code read address issued
    logic [15:0]      code_addr;
    logic [15:0]      jtgt;
    logic             jvld;
    logic [7:0]       rd_data;
    logic             rd_vld;
    logic             soft_reset_bit;
    logic             dev_o;
    logic             dev_e;
  } state_t;
  state_t s_reg, s_next;
  logic sel;            // selected pointer index
  logic [15:0] ea;      // acc plus pointer
  logic [15:0] fa;      // frame address
  assign sel = s_reg.aux[aux_pkg::DPS_POS];
  assign ea  = s_reg.data_pointer[sel] + {8'h00, ACC_I};
  // info-space byte lookup
  function automatic logic [7:0] info_byte(input state_t s, input logic [15:0] a);
    if (a == aux_pkg::SIG0_ADDR) info_byte = aux_pkg::SIG0_DEFAULT;
    else if (a == aux_pkg::SIG1_ADDR) info_byte = aux_pkg::SIG1_DEFAULT;
    else if (a == aux_pkg::SIG2_ADDR) info_byte = aux_pkg::SIG2_DEFAULT;
    else if (a >= aux_pkg::CUST_BASE && a <= aux_pkg::CUST_LAST)
      info_byte = s.cust[a[4:0]];
    else info_byte = aux_pkg::BLANK_BYTE;
  endfunction
  // next state
  always_comb
  begin
    s_next = s_reg;
    fa = 16'h0000;
    s_next.jvld = 1'b0;
    s_next.rd_vld = 1'b0;
    s_next.soft_reset_bit = 1'b0;
    s_next.pclk_d = link.pclk;
    // core pointer operations on selected pointer, and aux register write
    case (OP_I)
      aux_pkg::OP_INC:   s_next.data_pointer[sel] = s_reg.data_pointer[sel] + 16'h0001;
      aux_pkg::OP_LOAD:  s_next.data_pointer[sel] = OP_DATA_I;
      aux_pkg::OP_WR_LO: s_next.data_pointer[sel][7:0] = OP_DATA_I[7:0];
      aux_pkg::OP_WR_HI: s_next.data_pointer[sel][15:8] = OP_DATA_I[7:0];
      aux_pkg::OP_WR_AUX:
      begin
        s_next.aux = OP_DATA_I[7:0] & aux_pkg::AUX_WMASK;
        s_next.soft_reset_bit = OP_DATA_I[aux_pkg::SOFT_RESET_BIT_POS];
      end
      default: s_next.aux = s_reg.aux;
    endcase
    // indirect jump
    if (JMP_I)
    begin
      s_next.jtgt = ea;
      s_next.jvld = 1'b1;
    end
    // code read: info space or main code memory
    if (CODE_RD_I)
    begin
      s_next.code_addr = ea;
      s_next.rd_pend = (ea < aux_pkg::SIG0_ADDR) || (ea > aux_pkg::CUST_LAST);
      if (!s_next.rd_pend)
      begin
        s_next.rd_data = info_byte(s_reg, ea);
        s_next.rd_vld = 1'b1;
      end
    end
    else if (s_reg.rd_pend)
    begin
      s_next.rd_pend = 1'b0;
      s_next.rd_data = CODE_DATA_I;
      s_next.rd_vld = 1'b1;
    end
    // external data read returns latched config byte at CFG1_ADDR, blank byte elsewhere
    if (XDATA_RD_I)
    begin
      s_next.rd_data = (s_reg.data_pointer[sel] == aux_pkg::CFG1_ADDR) ?
                       s_reg.cfg_lat : aux_pkg::BLANK_BYTE;
      s_next.rd_vld = 1'b1;
    end
    // serial programming slave, sampled on strobe rise
    if (PROG_MODE_I && link.pclk && !s_reg.pclk_d)
    begin
      s_next.sh = {s_reg.sh[14:0], link.pdat};
      s_next.cnt = s_reg.cnt + 5'h01;
      s_next.dev_e = 1'b0;
      if (s_reg.cnt == 5'(aux_pkg::FRAME_BITS - 1))
      begin
        s_next.cnt = 5'h00;
        fa = {10'h000, s_next.sh[13:8]};
        case (s_next.sh[15:14])
          aux_pkg::CMD_CFG:  s_next.cfg = s_next.sh[7:0];
          aux_pkg::CMD_CUST: s_next.cust[fa[4:0]] = s_next.sh[7:0];
          default:
          begin
            // verify: drive msb of addressed customer byte on data pin until next strobe rise
            s_next.dev_o = s_reg.cust[fa[4:0]][7];
            s_next.dev_e = 1'b1;
          end
        endcase
      end
    end
    if (!PROG_MODE_I)
    begin
      s_next.cnt = 5'h00;
      s_next.dev_e = 1'b0;
    end
  end
  // state register; soft reset reinitialises pointers and aux
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      s_reg <= '0;
      s_reg.cfg <= aux_pkg::CFG1_RESET;
      s_reg.cfg_lat <= aux_pkg::CFG1_RESET;
      s_reg.cust <= '1;
      s_reg.aux <= aux_pkg::AUX_RESET;
    end
    else if (CE_I)
    begin
      s_reg <= s_next;
      if (s_reg.soft_reset_bit)
      begin
        s_reg.aux <= aux_pkg::AUX_RESET;
        s_reg.data_pointer <= '0;
        s_reg.cfg_lat <= s_reg.cfg;
      end
    end
  end
  assign CODE_ADDR_O   = s_reg.code_addr;
  assign JMP_TGT_O     = s_reg.jtgt;
  assign JMP_VLD_O     = s_reg.jvld;
  assign RD_DATA_O     = s_reg.rd_data;
  assign RD_VLD_O      = s_reg.rd_vld;
  assign AUX_O         = s_reg.aux;
  assign DPL_O         = s_reg.data_pointer[sel][7:0];
  assign DPH_O         = s_reg.data_pointer[sel][15:8];
  assign SOFT_RST_O    = s_reg.soft_reset_bit;
  assign WDT_RST_EN_O  = s_reg.cfg_lat[aux_pkg::WATCHDOG_ENABLE_CFG_POS];
  assign RST_PIN_EN_O  = ~s_reg.cfg_lat[aux_pkg::RPD_POS];
  assign PORT_RST_HI_O = s_reg.cfg_lat[aux_pkg::PORT_RESET_LEVEL_CFG_POS];
  assign OSC_SEL_O     = aux_pkg::osc_decode(s_reg.cfg_lat[2:0]);
  assign link.pdat_dev_o = s_reg.dev_o;
  assign link.pdat_dev_e = s_reg.dev_e;
endmodule

//--- hdl/aux_pkg.sv
package aux_pkg;
  localparam logic [7:0]  AUX_RESET      = 8'h00;  // aux register reset value
  localparam int          SOFT_RESET_BIT_POS       = 3;      // soft reset bit
  localparam int          DPS_POS        = 0;      // pointer select bit
  localparam logic [7:0]  AUX_WMASK      = 8'hF9;  // bits 2 and 1 read zero
  localparam logic [15:0] SIG0_ADDR      = 16'hFC30;
  localparam logic [15:0] SIG1_ADDR      = 16'hFC31;
  localparam logic [15:0] SIG2_ADDR      = 16'hFC60;
  localparam logic [15:0] CUST_BASE      = 16'hFCE0;
  localparam logic [15:0] CUST_LAST      = 16'hFCFF;
  localparam logic [15:0] CFG1_ADDR      = 16'hFD00;
  localparam logic [7:0]  CFG1_RESET     = 8'hFF;  // unprogrammed value
  localparam int          WATCHDOG_ENABLE_CFG_POS       = 7;
  localparam int          RPD_POS        = 6;
  localparam int          PORT_RESET_LEVEL_CFG_POS       = 5;
  localparam logic [7:0]  BLANK_BYTE     = 8'hFF;  // unmapped read value
  localparam logic [7:0]  SIG0_DEFAULT   = 8'h15;  // arbitrary signature value
  localparam logic [7:0]  SIG1_DEFAULT   = 8'h2A;  // arbitrary signature value
  localparam logic [7:0]  SIG2_DEFAULT   = 8'h3C;  // arbitrary signature value
  // programmer serial command codes
  localparam logic [1:0]  CMD_CFG        = 2'h0;
  localparam logic [1:0]  CMD_CUST       = 2'h1;
  localparam logic [1:0]  CMD_SIG        = 2'h2;
  localparam int          FRAME_BITS     = 16;     // 2 cmd + 6 addr + 8 data
  typedef enum logic [2:0] {
    OSC_HF  = 3'h0,
    OSC_MF  = 3'h1,
    OSC_LF  = 3'h2,
    OSC_RC  = 3'h3,
    OSC_EXT = 3'h7,
    OSC_RSV = 3'h4
  } osc_t;
  typedef enum logic [2:0] {
    OP_NONE   = 3'h0,
    OP_INC    = 3'h1,
    OP_LOAD   = 3'h2,
    OP_WR_LO  = 3'h3,
    OP_WR_HI  = 3'h4,
    OP_WR_AUX = 3'h5
  } core_op_t;
  // oscillator field decode
  function automatic osc_t osc_decode(input logic [2:0] f);
    case (f)
      3'h7:    osc_decode = OSC_EXT;
      3'h3:    osc_decode = OSC_RC;
      3'h2:    osc_decode = OSC_LF;
      3'h1:    osc_decode = OSC_MF;
      3'h0:    osc_decode = OSC_HF;
      default: osc_decode = OSC_RSV;
    endcase
  endfunction
endpackage

//--- hdl/aux_prog.sv
`timescale 1ns/1ns
// programmer end: shifts one 16-bit frame over the two-pin link
module aux_prog (
  input  wire logic        CLK_I,     // core clock
  input  wire logic        SYS_RST_I, // sync reset, high
  input  wire logic        CE_I,      // clock enable
  input  wire logic        START_I,   // send one frame
  input  wire logic [1:0]  CMD_I,     // command code
  input  wire logic [5:0]  ADDR_I,    // byte index
  input  wire logic [7:0]  DATA_I,    // data byte
  output logic             BUSY_O,    // frame in progress
  output logic             DONE_O,    // frame finished pulse
  prog_link_if.programmer  link       // serial programming pins
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOW  = 2'b01,
    ST_HIGH = 2'b10
  } st_t;
  typedef struct packed {
    st_t         st;
    logic [15:0] sh;
    logic [4:0]  cnt;
    logic        pclk;
    logic        busy;
    logic        done;
  } state_t;
  state_t s_reg, s_next;
  // frame sequencer, two core cycles per bit
  always_comb
  begin
    s_next = s_reg;
    s_next.done = 1'b0;
    case (s_reg.st)
      ST_IDLE:
      begin
        if (START_I)
        begin
          s_next.sh = {CMD_I, ADDR_I, DATA_I};
          s_next.cnt = 5'h00;
          s_next.busy = 1'b1;
          s_next.st = ST_LOW;
        end
      end
      ST_LOW:
      begin
        s_next.pclk = 1'b1; // device samples here
        s_next.st = ST_HIGH;
      end
      ST_HIGH:
      begin
        s_next.pclk = 1'b0;
        s_next.sh = {s_reg.sh[14:0], 1'b0};
        s_next.cnt = s_reg.cnt + 5'h01;
        s_next.st = ST_LOW;
        if (s_reg.cnt == 5'(aux_pkg::FRAME_BITS - 1))
        begin
          s_next.busy = 1'b0;
          s_next.done = 1'b1;
          s_next.st = ST_IDLE;
        end
      end
      default: s_next.st = ST_IDLE;
    endcase
  end
  // state register
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
      s_reg <= '0;
    else if (CE_I)
      s_reg <= s_next;
  end
  assign BUSY_O          = s_reg.busy;
  assign DONE_O          = s_reg.done;
  assign link.pclk       = s_reg.pclk;
  assign link.pdat_prg_o = s_reg.sh[15];
  assign link.pdat_prg_e = s_reg.busy;
endmodule

//--- hdl/prog_link_if.sv
`timescale 1ns/1ns
// two-pin serial programming link
interface prog_link_if;
  logic pclk;       // serial clock strobe from programmer
  logic pdat_prg_o; // programmer drives data
  logic pdat_prg_e; // programmer output enable
  logic pdat_dev_o; // device drives data
  logic pdat_dev_e; // device output enable
  logic pdat;       // resolved data level
  assign pdat = pdat_prg_e ? pdat_prg_o : (pdat_dev_e ? pdat_dev_o : 1'b1);
  modport device (input pclk, input pdat, output pdat_dev_o, output pdat_dev_e);
  modport programmer (output pclk, input pdat, output pdat_prg_o, output pdat_prg_e);
endinterface

//--- test/aux_control_and_config_checker.sv
`timescale 1ns/1ns
// temporal checks on the core side and the serial link
module aux_control_and_config_checker (
  input wire logic              CLK_I,      // core clock
  input wire logic              SYS_RST_I,  // sync reset
  input wire aux_pkg::core_op_t OP_I,       // core op
  input wire logic [15:0]       OP_DATA_I,  // operand
  input wire logic              JMP_I,      // jump request
  input wire logic [7:0]        ACC_I,      // accumulator
  input wire logic              XDATA_RD_I, // info read request
  input wire logic              JMP_VLD_O,  // jump valid
  input wire logic [15:0]       JMP_TGT_O,  // jump target
  input wire logic              RD_VLD_O,   // read valid
  input wire logic [7:0]        AUX_O,      // aux readback
  input wire logic [7:0]        DPL_O,      // pointer low
  input wire logic [7:0]        DPH_O,      // pointer high
  input wire logic              SOFT_RST_O, // soft reset pulse
  input wire logic              BUSY_O,     // frame busy
  input wire logic              DONE_O,     // frame done
  input wire logic              pclk,       // serial clock
  input wire logic              pdat_prg_e, // programmer enable
  input wire logic              pdat_dev_e  // device enable
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (SYS_RST_I);
  // selected pointer as one word
  wire logic [15:0] ptr = {DPH_O, DPL_O};
  a_soft_rst_pulse: assert property ((OP_I == aux_pkg::OP_WR_AUX && OP_DATA_I[3]) |=>
    SOFT_RST_O ##1 (!SOFT_RST_O && AUX_O == 8'h00 && ptr == 16'h0000))
    else $error("soft reset pulse or clear wrong");
  a_aux_bits_zero: assert property (AUX_O[2:1] == 2'h0)
    else $error("aux bit 2 or 1 not zero");
  a_aux_write_mask: assert property ((OP_I == aux_pkg::OP_WR_AUX && !OP_DATA_I[3]) |=>
    {8'h00, AUX_O} == ($past(OP_DATA_I) & 16'h00F9)) else $error("aux write value wrong");
  a_inc_selected: assert property (OP_I == aux_pkg::OP_INC |=> ptr == $past(ptr) + 16'h0001)
    else $error("pointer increment wrong");
  a_load_selected: assert property (OP_I == aux_pkg::OP_LOAD |=> ptr == $past(OP_DATA_I))
    else $error("pointer load wrong");
  a_ptr_hold: assert property ((OP_I == aux_pkg::OP_NONE && !SOFT_RST_O) |=> $stable(ptr))
    else $error("pointer changed without op");
  a_jump_target: assert property (JMP_I |=>
    JMP_VLD_O && JMP_TGT_O == $past(ptr) + {8'h00, $past(ACC_I)}) else $error("jump target wrong");
  a_xdata_valid: assert property (XDATA_RD_I |=> RD_VLD_O)
    else $error("info read not answered");
  a_link_idle_clk: assert property (!BUSY_O |-> !pclk)
    else $error("serial clock moves outside frame");
  a_no_contention: assert property (pdat_dev_e |-> !pdat_prg_e)
    else $error("both ends drive data");
  a_frame_length: assert property ($rose(BUSY_O) |-> ##[28:34] DONE_O)
    else $error("frame length wrong");
  c_soft_reset: cover property (SOFT_RST_O);
  c_frame_done: cover property (DONE_O);
  c_jump: cover property (JMP_VLD_O);
endmodule

//--- test/aux_control_and_config_tb.sv
`timescale 1ns/1ns
// both ends joined over the link; core side driven at falling edges
module aux_control_and_config_tb;
  logic              clk = 1'b0, rst = 1'b1, prog_mode = 1'b0;  // clock, reset, mode
  aux_pkg::core_op_t op = aux_pkg::OP_NONE;                    // core op
  logic [15:0]       op_data = 16'h0000;                       // operand
  logic              jmp = 1'b0, code_rd = 1'b0, xd_rd = 1'b0; // request pulses
  logic [7:0]        acc = 8'h00, code_byte = 8'h00;           // acc, main code byte
  logic              start = 1'b0;                             // frame start
  logic [1:0]        cmd = 2'h0;                               // frame command
  logic [5:0]        addr = 6'h00;                             // frame index
  logic [7:0]        data = 8'h00;                             // frame data
  logic [15:0]       code_addr, jmp_tgt;                       // core addresses
  logic              jmp_vld, rd_vld, soft_rst, busy, done;    // core and frame flags
  logic [7:0]        rd_data, aux, pointer_low_byte, pointer_high_byte;                   // core bytes
  logic              wdt_en, rpin_en, port_hi;                 // config outputs
  aux_pkg::osc_t     osc;                                      // clock source
  logic [15:0]       mp [2];                                   // pointer model
  logic [7:0]        maux = 8'h00, lat = 8'hFF, cfg;           // aux and config model
  logic              pclk_q = 1'b0;                            // last serial clock
  logic [15:0]       frame_sr = 16'h0000;                      // captured frame
  int                nbits = 0, n_mismatch = 0, samples_checked = 0;
  prog_link_if link_bus ();
  aux_ctrl u_aux_ctrl (.CLK_I(clk), .SYS_RST_I(rst), .CE_I(1'b1), .PROG_MODE_I(prog_mode),
    .OP_I(op), .OP_DATA_I(op_data), .JMP_I(jmp), .CODE_RD_I(code_rd), .XDATA_RD_I(xd_rd),
    .ACC_I(acc), .CODE_DATA_I(code_byte), .CODE_ADDR_O(code_addr), .JMP_TGT_O(jmp_tgt),
    .JMP_VLD_O(jmp_vld), .RD_DATA_O(rd_data), .RD_VLD_O(rd_vld), .AUX_O(aux), .DPL_O(pointer_low_byte),
    .DPH_O(pointer_high_byte), .SOFT_RST_O(soft_rst), .WDT_RST_EN_O(wdt_en), .RST_PIN_EN_O(rpin_en),
    .PORT_RST_HI_O(port_hi), .OSC_SEL_O(osc), .link(link_bus));
  aux_prog u_aux_prog (.CLK_I(clk), .SYS_RST_I(rst), .CE_I(1'b1), .START_I(start),
    .CMD_I(cmd), .ADDR_I(addr), .DATA_I(data), .BUSY_O(busy), .DONE_O(done), .link(link_bus));
  aux_control_and_config_checker u_checker (.CLK_I(clk), .SYS_RST_I(rst), .OP_I(op),
    .OP_DATA_I(op_data), .JMP_I(jmp), .ACC_I(acc), .XDATA_RD_I(xd_rd), .JMP_VLD_O(jmp_vld),
    .JMP_TGT_O(jmp_tgt), .RD_VLD_O(rd_vld), .AUX_O(aux), .DPL_O(pointer_low_byte), .DPH_O(pointer_high_byte),
    .SOFT_RST_O(soft_rst), .BUSY_O(busy), .DONE_O(done), .pclk(link_bus.pclk),
    .pdat_prg_e(link_bus.pdat_prg_e), .pdat_dev_e(link_bus.pdat_dev_e));
  // free running clock
  always #5 clk = ~clk;
  // capture data at each serial clock rise
  always @(posedge clk)
  begin
    pclk_q <= link_bus.pclk;
    if (link_bus.pclk === 1'b1 && pclk_q === 1'b0)
    begin
      frame_sr <= {frame_sr[14:0], link_bus.pdat};
      nbits    <= nbits + 1;
    end
  end
  // compare and count
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // verdict and end of run
  task automatic final_report();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // expected clock source from the field
  function automatic aux_pkg::osc_t exp_osc(input logic [2:0] f);
    case (f)
      3'h7:    exp_osc = aux_pkg::OSC_EXT;
      3'h3:    exp_osc = aux_pkg::OSC_RC;
      3'h2:    exp_osc = aux_pkg::OSC_LF;
      3'h1:    exp_osc = aux_pkg::OSC_MF;
      3'h0:    exp_osc = aux_pkg::OSC_HF;
      default: exp_osc = aux_pkg::OSC_RSV;
    endcase
  endfunction
  // aux and selected pointer against model
  task automatic chk_state();
    chk("aux", {8'h00, aux}, {8'h00, maux});
    chk("pointer", {pointer_high_byte, pointer_low_byte}, mp[maux[0]]);
  endtask
  // one core op, one cycle, model follows
  task automatic core_op(input aux_pkg::core_op_t o, input logic [15:0] d);
    op      = o;
    op_data = d;
    @(negedge clk);
    op = aux_pkg::OP_NONE;
    case (o)
      aux_pkg::OP_INC:    mp[maux[0]] = mp[maux[0]] + 16'h0001;
      aux_pkg::OP_LOAD:   mp[maux[0]] = d;
      aux_pkg::OP_WR_LO:  mp[maux[0]][7:0] = d[7:0];
      aux_pkg::OP_WR_HI:  mp[maux[0]][15:8] = d[7:0];
      aux_pkg::OP_WR_AUX: maux = d[7:0] & 8'hF9;
      default:            maux = maux;
    endcase
  endtask
  // soft reset through the aux register
  task automatic soft_reset();
    core_op(aux_pkg::OP_WR_AUX, 16'h0008);
    chk("soft rst", {15'h0000, soft_rst}, 16'h0001);
    @(negedge clk);
    chk("soft rst end", {15'h0000, soft_rst}, 16'h0000);
    maux  = 8'h00;
    mp[0] = 16'h0000;
    mp[1] = 16'h0000;
    chk_state();
  endtask
  // code or info read, main code answers one cycle later
  task automatic rd(input logic main, input logic xd, input logic [7:0] a, input logic [7:0] e);
    acc     = a;
    code_rd = !xd;
    xd_rd   = xd;
    @(negedge clk);
    code_rd = 1'b0;
    xd_rd   = 1'b0;
    if (main)
    begin
      chk("code addr", code_addr, mp[maux[0]] + {8'h00, a});
      @(negedge clk);
    end
    chk("rd vld", {15'h0000, rd_vld}, 16'h0001);
    chk("rd data", {8'h00, rd_data}, {8'h00, e});
  endtask
  // one programmer frame, checked on the wire
  task automatic send(input logic [1:0] c, input logic [5:0] ad, input logic [7:0] d);
    int k;
    @(negedge clk);
    chk("idle data", {15'h0000, link_bus.pdat}, 16'h0001);
    nbits = 0;
    start = 1'b1;
    cmd   = c;
    addr  = ad;
    data  = d;
    @(negedge clk);
    start = 1'b0;
    for (k = 0; k < 64 && done !== 1'b1; k++)
      @(negedge clk);
    chk("frame done", {15'h0000, done}, 16'h0001);
    chk("frame bits", nbits[15:0], 16'h0010);
    chk("frame word", frame_sr, {c, ad, d});
  endtask
  // hang guard
  initial
  begin
    #100000;
    n_mismatch++;
    final_report();
  end
  // main sequence
  initial
  begin
    int          i;
    logic [31:0] r;
    mp[0] = 16'h0000;
    mp[1] = 16'h0000;
    r = $urandom(32'hD962CE4C);
    repeat (12) @(negedge clk);
    rst = 1'b0;
    chk("reset cfg", {12'h000, wdt_en, rpin_en, port_hi, 1'b0}, 16'h000A);
    chk("reset osc", {13'h0000, osc}, {13'h0000, aux_pkg::OSC_EXT});
    chk_state();
    core_op(aux_pkg::OP_LOAD, aux_pkg::CFG1_ADDR);
    rd(1'b0, 1'b1, 8'h00, 8'hFF);
    core_op(aux_pkg::OP_LOAD, 16'hFFFF);
    core_op(aux_pkg::OP_INC, 16'h0000);
    chk_state();
    for (i = 0; i < 40; i++)
    begin
      r = $urandom();
      case (r[2:0])
        3'h0, 3'h1: core_op(aux_pkg::OP_INC, 16'h0000);
        3'h2:       core_op(aux_pkg::OP_LOAD, r[31:16]);
        3'h3:       core_op(aux_pkg::OP_WR_LO, {2{r[15:8]}});
        3'h4:       core_op(aux_pkg::OP_WR_HI, {2{r[15:8]}});
        3'h5:       core_op(aux_pkg::OP_WR_AUX, {8'h00, maux + 8'h01});
        default:    core_op(aux_pkg::OP_WR_AUX, {8'h00, r[15:8] & 8'hF7});
      endcase
      chk_state();
      jmp = 1'b1;
      acc = r[11:4];
      @(negedge clk);
      jmp = 1'b0;
      chk("jump", jmp_tgt, mp[maux[0]] + {8'h00, acc});
    end
    core_op(aux_pkg::OP_LOAD, aux_pkg::SIG0_ADDR);
    rd(1'b0, 1'b0, 8'h00, aux_pkg::SIG0_DEFAULT);
    rd(1'b0, 1'b0, 8'h01, aux_pkg::SIG1_DEFAULT);
    core_op(aux_pkg::OP_LOAD, aux_pkg::SIG2_ADDR);
    rd(1'b0, 1'b0, 8'h00, aux_pkg::SIG2_DEFAULT);
    core_op(aux_pkg::OP_LOAD, 16'h0123);
    code_byte = r[23:16];
    rd(1'b1, 1'b0, r[31:24], r[23:16]);
    prog_mode = 1'b1;
    send(aux_pkg::CMD_CUST, 6'h00, r[7:0]);
    send(aux_pkg::CMD_CUST, 6'h1F, r[15:8]);
    send(aux_pkg::CMD_SIG, 6'h00, 8'h00);
    chk("verify bit", {15'h0000, link_bus.pdat}, {15'h0000, r[7]});
    prog_mode = 1'b0;
    core_op(aux_pkg::OP_LOAD, aux_pkg::CUST_BASE);
    rd(1'b0, 1'b0, 8'h00, r[7:0]);
    rd(1'b0, 1'b0, 8'h1F, r[15:8]);
    for (i = 0; i < 8; i++)
    begin
      r         = $urandom();
      cfg       = {r[7:3], i[2:0]};
      prog_mode = 1'b1;
      send(aux_pkg::CMD_CFG, 6'h00, cfg);
      prog_mode = 0;
      chk("held cfg", {13'h0000, wdt_en, rpin_en, port_hi}, {13'h0000, lat[7], !lat[6], lat[5]});
      soft_reset();
      lat = cfg;
      chk("cfg", {13'h0000, wdt_en, rpin_en, port_hi}, {13'h0000, cfg[7], !cfg[6], cfg[5]});
      chk("osc", {13'h0000, osc}, {13'h0000, exp_osc(cfg[2:0])});
      core_op(aux_pkg::OP_LOAD, aux_pkg::CFG1_ADDR);
      rd(1'b0, 1'b1, 8'h00, cfg);
    end
    final_report();
  end
endmodule
